// *** hdl/isrb_map.svh ***
/*
 Register map and field constants of the interrupt state register bank.
 Assumes inclusion by its bare name from the bank's package and design file.
*/
`ifndef ISRB_MAP_SVH
`define ISRB_MAP_SVH
`define ISRB_RGN_ENA_SET 3'h0
`define ISRB_RGN_ENA_CLR 3'h1
`define ISRB_RGN_PND_SET 3'h2
`define ISRB_RGN_PND_CLR 3'h3
`define ISRB_RGN_ACTIVE  3'h4
`define ISRB_RGN_TARGET  3'h5
`define ISRB_RGN_CTRL    3'h6
`define ISRB_PRIO_SEL    10
`define ISRB_RGN_HI      9
`define ISRB_RGN_LO      7
`define ISRB_CTRL_NONSECURE_PRIORITY_SCALING   0
`define ISRB_ZERO32      32'h0000_0000
`define ISRB_PRIO_LOWEST 8'hff
`endif

// *** hdl/isrb_pkg.sv ***
/*
 Types shared by the interrupt state register bank.
 Assumes the map header is on the include path.
*/
`include "isrb_map.svh"
package isrb_pkg;
	typedef struct packed {
		logic [10:0] addr;
		logic        write;
		logic [2:0]  size;
		logic        nonsec;
	} isrb_aphase_t;
	typedef struct packed {
		logic       valid;
		logic [8:0] id;
		logic [7:0] prio;
	} isrb_cand_t;
endpackage

// *** hdl/isrb_top.sv ***
/*
 Interrupt state register bank: enable, pending, active, target and priority
 state per interrupt, an AHB-Lite slave, and the activation candidate picker.
 Assumes one AHB-Lite master, a security sideband valid with the address
 phase, and a core that reports entry and exit on mclk.
*/
// Functional notes
// - Enable-set word: write 1 enables interrupt, 0 ignored; reads enabled bits.
// - Pending enabled interrupts that are not active are offered for activation by priority.
// - A disabled interrupt's request still pends but is never offered.
// - Enable-clear word: write 1 disables, 0 ignored; reads enabled bits.
// - Pend-set word: write 1 pends interrupt, 0 ignored; reads pending bits.
// - Software pend-set works whatever the enable state.
// - Pend-set on an already pending interrupt changes nothing.
// - Active-status word shows one active bit per interrupt.
// - Target word bit: 0 Secure, 1 Non-secure; read and write.
// - Target words reachable from Secure only; else read zero, write ignored.
// - Non-secure access to Secure-targeted fields reads zero, writes ignored.
// - One shared copy of every state register for both security states.
// - Eight-bit priority field per interrupt, four to a word.
// - Priority words take word, halfword and byte writes by lane.
// - Interrupt M priority in word M/4, lane M mod 4, lane 0 lowest.
// - Lower priority value wins the activation choice.
// - Unimplemented low-order priority bits are held at zero.
// - Non-secure interrupts' effective priority follows the scaling bit.
// - Pend-clear word: write 1 clears pending, 0 ignored; reads pending.
// - Pend-clear leaves the active state alone.
`include "isrb_map.svh"
`timescale 1ns/100ps
`default_nettype none
module isrb_top #(
	parameter int NUM_IRQ   = 64,
	parameter int PRIO_BITS = 8
) (
	input  wire logic                 mclk,
	input  wire logic                 rst_b,
	input  wire logic                 hsel,
	input  wire logic [31:0]          haddr,
	input  wire logic [1:0]           htrans,
	input  wire logic                 hwrite,
	input  wire logic [2:0]           hsize,
	input  wire logic [31:0]          hwdata,
	input  wire logic                 hready,
	input  wire logic                 hnonsec,
	output logic [31:0]               hrdata,
	output logic                      hreadyout,
	output logic                      hresp,
	input  wire logic [NUM_IRQ-1:0]   irq_lines,
	input  wire logic                 core_enter,
	input  wire logic [8:0]           core_enter_id,
	input  wire logic                 core_exit,
	input  wire logic [8:0]           core_exit_id,
	output isrb_pkg::isrb_cand_t      cand
);
	import isrb_pkg::*;

	localparam logic [7:0] PRIO_MASK = 8'(9'h1ff << (8 - PRIO_BITS));

	logic [NUM_IRQ-1:0] sync1_ff;
	logic [NUM_IRQ-1:0] sync2_ff;
	logic [NUM_IRQ-1:0] line_d_ff;
	logic [NUM_IRQ-1:0] enable_ff;
	logic [NUM_IRQ-1:0] pend_ff;
	logic [NUM_IRQ-1:0] active_ff;
	logic [NUM_IRQ-1:0] target_ff;
	logic [7:0]         prio_ff [NUM_IRQ];
	logic               nonsecure_priority_scaling_ff;
	logic               hresp_ff;
	logic               dp_valid_ff;
	isrb_aphase_t       dp_ff;
	logic               hreadyout_ff;
	logic [31:0]        hrdata_ff;
	isrb_cand_t         cand_ff;
	isrb_cand_t         nxt_cand;
	logic [31:0]        rd_word;
	logic [NUM_IRQ-1:0] hit;
	logic [NUM_IRQ-1:0] dat;
	logic [NUM_IRQ-1:0] ok;
	logic [NUM_IRQ-1:0] prio_we;
	logic [NUM_IRQ-1:0] enter_vec;
	logic [NUM_IRQ-1:0] exit_vec;
	logic [NUM_IRQ-1:0] elig;
	logic [7:0]         eff [NUM_IRQ];
	logic [3:0]         be;
	logic [2:0]         rgn;
	logic               take;
	logic               wr_go;
	logic               wr_bits;

	assign hrdata    = hrdata_ff;
	assign hreadyout = hreadyout_ff;
	assign hresp     = hresp_ff;
	assign cand      = cand_ff;

	// Request lines come from other domains
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			sync1_ff  <= '0;
			sync2_ff  <= '0;
			line_d_ff <= '0;
		end else begin
			sync1_ff  <= irq_lines;
			sync2_ff  <= sync1_ff;
			line_d_ff <= sync2_ff;
		end
	end

	// Address phase capture
	assign take = hsel & htrans[1] & hready;
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			dp_valid_ff <= 1'b0;
			dp_ff       <= '0;
		end else if (hready) begin
			dp_valid_ff <= take;
			if (take) begin
				dp_ff <= '{haddr[10:0], hwrite, hsize, hnonsec};
			end
		end
	end

	// Always OKAY; registered like every other output
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			hresp_ff <= 1'b0;
		end else begin
			hresp_ff <= 1'b0;
		end
	end

	// One wait state on reads so a write just before is seen
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			hreadyout_ff <= 1'b1;
		end else begin
			hreadyout_ff <= !(take && !hwrite);
		end
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			hrdata_ff <= `ISRB_ZERO32;
		end else if (dp_valid_ff && !dp_ff.write && !hreadyout_ff) begin
			hrdata_ff <= rd_word;
		end else begin
			hrdata_ff <= `ISRB_ZERO32;
		end
	end

	assign wr_go   = dp_valid_ff & dp_ff.write & hreadyout_ff;
	assign rgn     = dp_ff.addr[`ISRB_RGN_HI:`ISRB_RGN_LO];
	assign wr_bits = wr_go & !dp_ff.addr[`ISRB_PRIO_SEL];

	// Lanes assume an aligned access
	always_comb begin
		unique case (dp_ff.size)
			3'h0:    be = 4'(4'h1 << dp_ff.addr[1:0]);
			3'h1:    be = dp_ff.addr[1] ? 4'hc : 4'h3;
			default: be = 4'hf;
		endcase
	end

	// Per-interrupt write decode
	always_comb begin
		for (int i = 0; i < NUM_IRQ; i++) begin
			ok[i]  = !dp_ff.nonsec || target_ff[i];
			hit[i] = wr_bits && (dp_ff.addr[6:2] == 5'(i / 32));
			dat[i] = hwdata[i % 32];
			prio_we[i] = wr_go && dp_ff.addr[`ISRB_PRIO_SEL] && ok[i]
				&& (dp_ff.addr[8:2] == 7'(i / 4)) && be[i % 4];
			enter_vec[i] = core_enter && (core_enter_id == 9'(i));
			exit_vec[i]  = core_exit && (core_exit_id == 9'(i));
		end
	end

	// Single copy shared by both security states
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			enable_ff <= '0;
		end else if (rgn == `ISRB_RGN_ENA_SET) begin
			enable_ff <= enable_ff | (hit & dat & ok);
		end else if (rgn == `ISRB_RGN_ENA_CLR) begin
			enable_ff <= enable_ff & ~(hit & dat & ok);
		end
	end

	// Set wins over every clear; level lines re-pend while not active
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			pend_ff <= '0;
		end else begin
			pend_ff <= (pend_ff
				& ~((rgn == `ISRB_RGN_PND_CLR) ? (hit & dat & ok) : '0)
				& ~enter_vec)
				| ((rgn == `ISRB_RGN_PND_SET) ? (hit & dat & ok) : '0)
				| (sync2_ff & ~line_d_ff)
				| (sync2_ff & ~(active_ff | enter_vec));
		end
	end

	// Only the core changes active state
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			active_ff <= '0;
		end else begin
			// Entry wins over a same-cycle exit
			active_ff <= (active_ff & ~exit_vec) | enter_vec;
		end
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			target_ff <= '0;
		end else if (rgn == `ISRB_RGN_TARGET && !dp_ff.nonsec) begin
			target_ff <= (target_ff & ~hit) | (hit & dat);
		end
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			nonsecure_priority_scaling_ff <= 1'b0;
		end else if (wr_bits && rgn == `ISRB_RGN_CTRL && !dp_ff.nonsec) begin
			nonsecure_priority_scaling_ff <= hwdata[`ISRB_CTRL_NONSECURE_PRIORITY_SCALING];
		end
	end

	// Low bits masked on write, so they can never hold a one
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			for (int i = 0; i < NUM_IRQ; i++) begin
				prio_ff[i] <= 8'h00;
			end
		end else begin
			for (int i = 0; i < NUM_IRQ; i++) begin
				if (prio_we[i]) begin
					prio_ff[i] <= hwdata[8 * (i % 4) +: 8] & PRIO_MASK;
				end
			end
		end
	end

	// Read mux; indices past NUM_IRQ stay zero
	always_comb begin
		int idx;
		rd_word = `ISRB_ZERO32;
		idx = 0;
		if (dp_ff.addr[`ISRB_PRIO_SEL]) begin
			for (int l = 0; l < 4; l++) begin
				idx = 4 * int'(dp_ff.addr[8:2]) + l;
				if (idx < NUM_IRQ && (!dp_ff.nonsec || target_ff[idx])) begin
					rd_word[8 * l +: 8] = prio_ff[idx];
				end
			end
		end else if (rgn == `ISRB_RGN_CTRL) begin
			rd_word[`ISRB_CTRL_NONSECURE_PRIORITY_SCALING] = nonsecure_priority_scaling_ff & !dp_ff.nonsec;
		end else begin
			for (int b = 0; b < 32; b++) begin
				idx = 32 * int'(dp_ff.addr[6:2]) + b;
				if (idx < NUM_IRQ && (!dp_ff.nonsec || target_ff[idx])) begin
					unique case (rgn)
						`ISRB_RGN_ENA_SET,
						`ISRB_RGN_ENA_CLR: rd_word[b] = enable_ff[idx];
						`ISRB_RGN_PND_SET,
						`ISRB_RGN_PND_CLR: rd_word[b] = pend_ff[idx];
						`ISRB_RGN_ACTIVE:  rd_word[b] = active_ff[idx];
						`ISRB_RGN_TARGET:  rd_word[b] = target_ff[idx] & !dp_ff.nonsec;
						default:           rd_word[b] = 1'b0;
					endcase
				end
			end
		end
	end

	// Non-secure interrupts fold into the lower-urgency half when scaled
	always_comb begin
		for (int i = 0; i < NUM_IRQ; i++) begin
			eff[i] = prio_ff[i];
			if (target_ff[i] && nonsecure_priority_scaling_ff) begin
				eff[i] = {1'b1, prio_ff[i][7:1]};
			end
			elig[i] = pend_ff[i] & enable_ff[i] & ~active_ff[i];
		end
	end

	// Linear scan; ties go to the lower number
	always_comb begin
		nxt_cand = '{1'b0, 9'h000, `ISRB_PRIO_LOWEST};
		for (int i = 0; i < NUM_IRQ; i++) begin
			if (elig[i] && (!nxt_cand.valid || eff[i] < nxt_cand.prio)) begin
				nxt_cand = '{1'b1, 9'(i), eff[i]};
			end
		end
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			cand_ff <= '{1'b0, 9'h000, `ISRB_PRIO_LOWEST};
		end else begin
			cand_ff <= nxt_cand;
		end
	end

	AST_ENA_SET: assert property (@(posedge mclk) disable iff (!rst_b)
		wr_bits && rgn == `ISRB_RGN_ENA_SET && dp_ff.addr[6:2] == 5'h00 && hwdata[0] && ok[0]
		|=> enable_ff[0]) else $error("enable set lost");

	AST_ENA_CLR: assert property (@(posedge mclk) disable iff (!rst_b)
		wr_bits && rgn == `ISRB_RGN_ENA_CLR && dp_ff.addr[6:2] == 5'h00 && hwdata[0] && ok[0]
		|=> !enable_ff[0]) else $error("enable clear lost");

	AST_PEND_SET: assert property (@(posedge mclk) disable iff (!rst_b)
		wr_bits && rgn == `ISRB_RGN_PND_SET && dp_ff.addr[6:2] == 5'h00 && hwdata[0] && ok[0]
		|=> pend_ff[0]) else $error("pend set lost");

	AST_HW_PEND: assert property (@(posedge mclk) disable iff (!rst_b)
		sync2_ff[0] && !line_d_ff[0] |=> pend_ff[0]) else $error("request edge not pended");

	AST_CAND_ELIG: assert property (@(posedge mclk) disable iff (!rst_b)
		cand_ff.valid |-> |($past(elig) & ({{(NUM_IRQ-1){1'b0}}, 1'b1} << cand_ff.id)))
		else $error("offered ineligible irq");

	AST_CLR_KEEPS_ACTIVE: assert property (@(posedge mclk) disable iff (!rst_b)
		wr_bits && rgn == `ISRB_RGN_PND_CLR && !core_enter && !core_exit
		|=> $stable(active_ff)) else $error("pend clear moved active");

	AST_PRIO_LOW_ZERO: assert property (@(posedge mclk) disable iff (!rst_b)
		(prio_ff[0] & ~PRIO_MASK) == 8'h00) else $error("low priority bits set");

	AST_NS_TARGET_RAZ: assert property (@(posedge mclk) disable iff (!rst_b)
		dp_valid_ff && !dp_ff.write && !hreadyout_ff && dp_ff.nonsec
		&& !dp_ff.addr[`ISRB_PRIO_SEL] && rgn == `ISRB_RGN_TARGET
		|=> hrdata_ff == `ISRB_ZERO32) else $error("target visible to non-secure");

	AST_READ_WAIT: assert property (@(posedge mclk) disable iff (!rst_b)
		take && !hwrite |=> !hreadyout_ff ##1 hreadyout_ff) else $error("read wait wrong");

	AST_PEND_CLR: assert property (@(posedge mclk) disable iff (!rst_b)
		wr_bits && rgn == `ISRB_RGN_PND_CLR && dp_ff.addr[6:2] == 5'h00 && hwdata[3] && ok[3]
		&& !sync2_ff[3] |=> !pend_ff[3]) else $error("pend clear lost");

	AST_NS_TARGET_WI: assert property (@(posedge mclk) disable iff (!rst_b)
		wr_bits && rgn == `ISRB_RGN_TARGET && dp_ff.nonsec
		|=> $stable(target_ff)) else $error("non-secure target write took effect");

	AST_NS_ENA_WI: assert property (@(posedge mclk) disable iff (!rst_b)
		wr_bits && rgn == `ISRB_RGN_ENA_CLR && dp_ff.nonsec && !target_ff[0] && enable_ff[0]
		|=> enable_ff[0]) else $error("non-secure write reached secure enable");

endmodule
`default_nettype wire

// *** testbench/isrb_core_model.sv ***
/*
 Core-side partner: takes the offered candidate on a strobe, leaves it later.
 Assumes take and leave strobes from the bench, all on mclk.
*/
`timescale 1ns/100ps
`default_nettype none
module isrb_core_model (
	input  wire logic                 mclk,
	input  wire logic                 rst_b,
	input  wire isrb_pkg::isrb_cand_t cand,
	input  wire logic                 take,
	input  wire logic                 leave,
	output logic                      core_enter,
	output logic [8:0]                core_enter_id,
	output logic                      core_exit,
	output logic [8:0]                core_exit_id
);
	import isrb_pkg::*;
	logic [8:0] held_ff;
	// Ids flip while idle so a stale id never passes for a live one
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			core_enter <= 1'b0;
			core_enter_id <= 9'h000;
			core_exit <= 1'b0;
			core_exit_id <= 9'h000;
			held_ff <= 9'h000;
		end else begin
			core_enter <= take & cand.valid;
			core_enter_id <= (take & cand.valid) ? cand.id : ~core_enter_id;
			held_ff <= (take & cand.valid) ? cand.id : held_ff;
			core_exit <= leave;
			core_exit_id <= leave ? held_ff : ~core_exit_id;
		end
	end
endmodule
`default_nettype wire

// *** testbench/isrb_bench.sv ***
/*
 Self-checking bench for the register bank: AHB-Lite reads and writes,
 request lines, and a core model taking and leaving interrupts.
 Assumes the bank with 64 interrupts and 4 priority bits.
*/
`timescale 1ns/100ps
`default_nettype none
module isrb_bench;
	import isrb_pkg::*;
	logic        mclk = 1'b0;
	logic        rst_b = 1'b0;
	logic        hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0]  htrans = 2'h0;
	logic        hwrite = 1'b0;
	logic [2:0]  hsize = 3'h2;
	logic [31:0] hwdata = 32'h0;
	logic        hnonsec = 1'b0;
	logic [31:0] hrdata;
	logic        hreadyout;
	logic        hresp;
	logic        rsp;
	logic [63:0] irq_lines = 64'h0;
	logic        take = 1'b0;
	logic        leave = 1'b0;
	logic        core_enter;
	logic        core_exit;
	logic [8:0]  core_enter_id;
	logic [8:0]  core_exit_id;
	isrb_cand_t  cand;
	logic [31:0] rd;
	int          bad_count = 0;
	int          tests_run = 0;
	always #12.5 mclk = ~mclk;
	isrb_top #(.NUM_IRQ(64), .PRIO_BITS(4)) dut_u (.mclk(mclk), .rst_b(rst_b),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hreadyout), .hnonsec(hnonsec), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .irq_lines(irq_lines),
		.core_enter(core_enter), .core_enter_id(core_enter_id),
		.core_exit(core_exit), .core_exit_id(core_exit_id), .cand(cand));
	isrb_core_model model_u (.mclk(mclk), .rst_b(rst_b), .cand(cand), .take(take),
		.leave(leave), .core_enter(core_enter), .core_enter_id(core_enter_id),
		.core_exit(core_exit), .core_exit_id(core_exit_id));
	task automatic finish_test();
		$display("Checks %0d, mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			bad_count++;
			$display("[ERR] %0t got %h want %h", $time, got, exp);
		end
	endtask
	task automatic rdy();
		int n;
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while (hreadyout !== 1'b1 && n < 20);
		if (hreadyout !== 1'b1) begin
			bad_count++;
			$display("[ERR] %0t bus hang", $time);
			finish_test();
		end
	endtask
	// Aligned single transfers only
	task automatic bus(input logic [31:0] a, input logic w, input logic ns,
			input logic [2:0] sz, input logic [31:0] wd);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		hsize <= sz;
		hnonsec <= ns;
		rdy();
		htrans <= 2'h0;
		hwdata <= wd;
		rdy();
		rd = hrdata;
		rsp = hresp;
	endtask
	task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic ns = 1'b0);
		bus(a, 1'b1, ns, 3'h2, d);
	endtask
	task automatic rc(input logic [31:0] a, input logic [31:0] e, input logic ns = 1'b0);
		bus(a, 1'b0, ns, 3'h2, 32'h0);
		chk(rd, e);
		chk({31'h0, rsp}, 32'h0);
	endtask
	task automatic pick(input logic [8:0] id, input logic [7:0] pr);
		repeat (2) @(posedge mclk);
		chk({31'h0, cand.valid}, 32'h1);
		chk({23'h0, cand.id}, {23'h0, id});
		chk({24'h0, cand.prio}, {24'h0, pr});
	endtask
	initial begin
		repeat (3) @(posedge mclk);
		rst_b <= 1'b1;
		@(posedge mclk);
		rc(32'h000, 32'h0);
		rc(32'h100, 32'h0);
		rc(32'h280, 32'h0);
		wr(32'h000, 32'h0000_00a5);
		wr(32'h000, 32'h0);
		rc(32'h000, 32'h0000_00a5);
		wr(32'h080, 32'h0000_0081);
		rc(32'h080, 32'h0000_0024);
		wr(32'h080, 32'hffff_ffff);
		wr(32'h008, 32'hffff_ffff);
		rc(32'h008, 32'h0);
		wr(32'h440, 32'hffff_ffff);
		rc(32'h440, 32'h0);
		$display("Test done: enables");
		wr(32'h104, 32'h0000_0008);
		wr(32'h104, 32'h0000_0008);
		rc(32'h104, 32'h0000_0008);
		rc(32'h184, 32'h0000_0008);
		chk({31'h0, cand.valid}, 32'h0);
		wr(32'h184, 32'h0000_0008);
		rc(32'h104, 32'h0);
		irq_lines[40] <= 1'b1;
		repeat (4) @(posedge mclk);
		irq_lines[40] <= 1'b0;
		rc(32'h104, 32'h0000_0100);
		wr(32'h184, 32'h0000_0100);
		$display("Test done: pending");
		bus(32'h401, 1'b1, 1'b0, 3'h0, 32'h0000_4000);
		bus(32'h402, 1'b1, 1'b0, 3'h1, 32'h1080_0000);
		rc(32'h400, 32'h1080_4000);
		wr(32'h400, 32'h1f80_4f8f);
		rc(32'h400, 32'h1080_4080);
		wr(32'h000, 32'h0000_0007);
		wr(32'h100, 32'h0000_000f);
		pick(9'h001, 8'h40);
		wr(32'h000, 32'h0000_0008);
		pick(9'h003, 8'h10);
		$display("Test done: priority");
		take <= 1'b1;
		@(posedge mclk);
		take <= 1'b0;
		repeat (3) @(posedge mclk);
		rc(32'h200, 32'h0000_0008);
		rc(32'h100, 32'h0000_0007);
		wr(32'h100, 32'h0000_0008);
		wr(32'h180, 32'h0000_0008);
		rc(32'h200, 32'h0000_0008);
		leave <= 1'b1;
		@(posedge mclk);
		leave <= 1'b0;
		repeat (3) @(posedge mclk);
		rc(32'h200, 32'h0);
		$display("Test done: core");
		wr(32'h280, 32'h0000_0002);
		rc(32'h280, 32'h0000_0002);
		wr(32'h280, 32'hffff_ffff, 1'b1);
		rc(32'h280, 32'h0, 1'b1);
		rc(32'h280, 32'h0000_0002);
		rc(32'h000, 32'h0000_0002, 1'b1);
		rc(32'h400, 32'h0000_4000, 1'b1);
		wr(32'h080, 32'hffff_ffff, 1'b1);
		rc(32'h000, 32'h0000_000d);
		wr(32'h000, 32'h0000_0002);
		pick(9'h001, 8'h40);
		wr(32'h300, 32'h0000_0001);
		pick(9'h000, 8'h80);
		rc(32'h300, 32'h0000_0001);
		rc(32'h300, 32'h0, 1'b1);
		wr(32'h380, 32'hffff_ffff);
		rc(32'h380, 32'h0);
		$display("Test done: security");
		finish_test();
	end
endmodule
`default_nettype wire
